// *** dv/opc_ctrl_asserts.sv ***
// Port-level checks for the programmer controller
`default_nettype none

module opc_ctrl_asserts
   import opc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   input wire logic [31:0] DAT_O,
   input wire logic [ADDR_W-1:0] MEM_ADDR_O,
   input wire logic CHIP_EN_N_O,
   input wire logic OUT_EN_N_O,
   input wire logic PROGRAM_STROBE_N_O,
   input wire logic PROG_VOLT_EN_O,
   input wire logic PROTECT_VOLTAGE_INPUT_O,
   input wire logic PROC_CLK_STOP_O,
   input wire logic [7:0] PROGRAMMER_DATA_LINES_O,
   input wire logic [7:0] PROGRAMMER_DATA_LINES_OE_O
);
   // ------------------------------------------------------------
   // Strobe width counter
   // ------------------------------------------------------------
   int unsigned lo_cnt_q;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   always_ff @(posedge CLK_I) begin
      if (RESET_I || PROGRAM_STROBE_N_O) lo_cnt_q <= 0;
      else lo_cnt_q <= lo_cnt_q + 1;
   end

   AST_PULSE_W: assert property ($rose(PROGRAM_STROBE_N_O) |->
      lo_cnt_q == SHORT_CYC || lo_cnt_q == PRIME_CYC ||
      (lo_cnt_q % (3 * PRIME_CYC) == 0 && lo_cnt_q != 0 && lo_cnt_q <= 75 * PRIME_CYC))
      else $error("strobe pulse of illegal width");
   AST_SETTLE: assert property ($fell(PROGRAM_STROBE_N_O) |-> $stable(MEM_ADDR_O) &&
      $stable(PROGRAMMER_DATA_LINES_O) && PROGRAMMER_DATA_LINES_OE_O == 8'hFF)
      else $error("strobe fell before address and data settled");
   AST_HOLD: assert property ((!PROGRAM_STROBE_N_O) [*2] |-> $stable(MEM_ADDR_O) &&
      $stable(PROGRAMMER_DATA_LINES_O)) else $error("address or data moved under strobe");
   AST_PROG_MODE: assert property (!PROGRAM_STROBE_N_O |-> !CHIP_EN_N_O &&
      OUT_EN_N_O && PROG_VOLT_EN_O) else $error("strobe low outside program mode");
   AST_NO_FIGHT: assert property (!CHIP_EN_N_O && !OUT_EN_N_O |->
      PROGRAMMER_DATA_LINES_OE_O == 8'h00) else $error("controller drives during read");
   AST_CLK_STOP: assert property (!CHIP_EN_N_O || PROG_VOLT_EN_O ||
      PROTECT_VOLTAGE_INPUT_O |-> PROC_CLK_STOP_O) else $error("processor clock running");
   AST_PROTECT: assert property (PROTECT_VOLTAGE_INPUT_O && PROGRAMMER_DATA_LINES_OE_O[7] &&
      !PROGRAMMER_DATA_LINES_O[7] |-> CHIP_EN_N_O && OUT_EN_N_O && PROGRAM_STROBE_N_O &&
      MEM_ADDR_O[4] && PROG_VOLT_EN_O) else $error("protect pulse with wrong levels");
   AST_ACK_LAT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("no acknowledge one cycle after request");
   AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O) else $error("acknowledge held");
   AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data not zero");
endmodule // opc_ctrl_asserts

`default_nettype wire

// *** dv/opc_ctrl_tb_top.sv ***
// Self-checking bench for the programmer controller
`default_nettype none

module opc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import opc_pkg::*;

   logic clk, rst, cyc, stb, we, ack, ce_n, oe_n, strb_n, vpp, pv_in, clk_stop, alg;
   logic [3:0] adr, sel, need;
   logic [31:0] wdat, rdat, rd;
   logic [ADDR_W-1:0] maddr;
   logic [7:0] pdat, poe, bus;
   logic [11:0] a1, a2;
   logic [15:0] d1, d2;
   int seed, fail_count, checks, cyc_cnt;

   opc_ctrl u_dut (.CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .MEM_ADDR_O(maddr),
      .CHIP_EN_N_O(ce_n), .OUT_EN_N_O(oe_n), .PROGRAM_STROBE_N_O(strb_n),
      .PROG_VOLT_EN_O(vpp), .PROTECT_VOLTAGE_INPUT_O(pv_in), .PROC_CLK_STOP_O(clk_stop),
      .PROGRAMMER_DATA_LINES_O(pdat), .PROGRAMMER_DATA_LINES_OE_O(poe),
      .DEVICE_DATA_LINES_I(bus));

   opc_dev_model u_dev (.clk_i(clk), .addr_i(maddr), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .strobe_n_i(strb_n), .vpp_i(vpp), .prot_volt_i(pv_in), .prog_d_i(pdat), .prog_oe_i(poe),
      .need_i(need), .bus_o(bus));

   // ------------------------------------------------------------
   // Clock, watchdog, helpers
   // ------------------------------------------------------------
   initial clk = 1'b0;
   always #4 clk = ~clk;

   task automatic wrap_up();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Whole run needs about 88k cycles, mostly strobe pulses
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 98000) begin
         fail_count++;
         wrap_up();
      end
   end

   function automatic logic [31:0] ctrl_val(logic [2:0] c, logic a, logic go);
      return {27'h0, go, a, c};
   endfunction

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wait_idle();
      do wb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
   endtask

   task automatic run_cmd(input logic [2:0] c, input logic [11:0] a);
      wb(1'b1, REG_ADDR, {20'h0, a});
      wb(1'b1, REG_CTRL, ctrl_val(c, 1'b1, 1'b1));
      if (c != CMD_PROG) wait_idle();
      if (c == CMD_READ || c == CMD_PVFY) wb(1'b0, REG_DATA, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 78157;
      {rst, cyc, stb, we, adr, wdat} = {1'b1, 39'h0};
      sel = 4'hF;
      need = 4'h1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (int c = 1; c < 5; c++) begin
         alg = 1'($random(seed));
         wb(1'b1, REG_CTRL, ctrl_val(3'(c), alg, 1'b0));
         wb(1'b0, REG_CTRL, 32'h0);
         chk("ctrl", rd & 32'hF, ctrl_val(3'(c), alg, 1'b0));
      end
      a1 = 12'($random(seed));
      d1 = 16'($random(seed));
      run_cmd(CMD_READ, a1);
      chk("blank", 32'(rd[31:16]), 32'hFFFF);
      wb(1'b1, REG_DATA, {16'h0, d1});
      run_cmd(CMD_PROG, a1);
      wb(1'b1, REG_ADDR, {20'h0, ~a1});
      wb(1'b0, REG_STAT, 32'h0);
      chk("busy", 32'(rd[0]), 32'h1);
      wb(1'b0, REG_ADDR, 32'h0);
      chk("addr_hold", rd & 32'hFFF, 32'(a1));
      wait_idle();
      chk("fail1", 32'(rd[2:1]), 32'h0);
      run_cmd(CMD_READ, a1);
      chk("word1", 32'(rd[31:16]), 32'(d1));
      // Slow cells: each byte needs a second pulse
      need <= 4'h2;
      a2 = a1 ^ 12'h800;
      // Bit 0 of each byte cleared so both bytes really need two pulses
      d2 = 16'($random(seed)) & 16'hFEFE;
      wb(1'b1, REG_DATA, {16'h0, d2});
      run_cmd(CMD_PROG, a2);
      wait_idle();
      chk("tries", 32'(rd[12:8]), 32'h2);
      chk("fail2", 32'(rd[2:1]), 32'h0);
      run_cmd(CMD_READ, a2);
      chk("word2", 32'(rd[31:16]), 32'(d2));
      run_cmd(CMD_PVFY, a2);
      chk("cell_open", 32'(rd[16]), 32'h1);
      run_cmd(CMD_PROT, a2);
      run_cmd(CMD_PVFY, a2);
      chk("cell_set", 32'(rd[16]), 32'h0);
      wrap_up();
   end
endmodule // opc_ctrl_tb_top

bind opc_ctrl opc_ctrl_asserts u_ast (.CLK_I(CLK_I), .RESET_I(RESET_I), .CYC_I(CYC_I),
   .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .MEM_ADDR_O(MEM_ADDR_O),
   .CHIP_EN_N_O(CHIP_EN_N_O), .OUT_EN_N_O(OUT_EN_N_O), .PROGRAM_STROBE_N_O(PROGRAM_STROBE_N_O),
   .PROG_VOLT_EN_O(PROG_VOLT_EN_O), .PROTECT_VOLTAGE_INPUT_O(PROTECT_VOLTAGE_INPUT_O),
   .PROC_CLK_STOP_O(PROC_CLK_STOP_O), .PROGRAMMER_DATA_LINES_O(PROGRAMMER_DATA_LINES_O),
   .PROGRAMMER_DATA_LINES_OE_O(PROGRAMMER_DATA_LINES_OE_O));

`default_nettype wire

// *** dv/opc_dev_model.sv ***
// Behavioural model of the one-time-programmable memory in programming mode
`default_nettype none

module opc_dev_model (
   input wire logic clk_i,
   input wire logic [12:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic strobe_n_i,
   input wire logic vpp_i,
   input wire logic prot_volt_i,
   input wire logic [7:0] prog_d_i,
   input wire logic [7:0] prog_oe_i,
   input wire logic [3:0] need_i,
   output logic [7:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:8191];
   logic [7:0] float_q;
   logic [7:0] dev_d;
   logic [12:0] last_a;
   logic [3:0] hits;
   logic prot_q;
   logic drive;

   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      prot_q = 1'b0;
      hits = 4'h0;
      last_a = 13'h0;
      float_q = 8'h55;
   end

   // Slow cells need several pulses on one byte before they stick
   // Taken at the falling edge, where the other pins are still steady
   always @(negedge strobe_n_i) begin
      if (!ce_n_i && oe_n_i && vpp_i) begin
         hits = (addr_i == last_a) ? hits + 4'h1 : 4'h1;
         last_a = addr_i;
         if (hits >= need_i) mem[addr_i] = mem[addr_i] & (prog_d_i | ~prog_oe_i);
      end
   end

   // Undriven lines wander so stale values never pass
   always @(posedge clk_i) begin
      float_q <= ~float_q;
      if (prot_volt_i && vpp_i && ce_n_i && oe_n_i && strobe_n_i && addr_i[4] && prog_oe_i[7] &&
          !prog_d_i[7]) prot_q <= 1'b1;
   end

   assign drive = !ce_n_i && !oe_n_i && strobe_n_i;
   // Protected array gives only floating nodes outward
   assign dev_d = prot_volt_i ? {~prot_q, float_q[6:0]} :
      (prot_q ? float_q : mem[addr_i]);
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         bus_o[i] = drive ? dev_d[i] : (prog_oe_i[i] ? prog_d_i[i] : float_q[i]);
      end
   end
endmodule // opc_dev_model

`default_nettype wire

// *** rtl/opc_ctrl.sv ***
// Host-side programmer controller for the one-time-programmable program memory
//
// Added by the designer: register access over Wishbone and the address map.
`default_nettype none

module opc_ctrl (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [3:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // Device pins
   output logic [opc_pkg::ADDR_W-1:0] MEM_ADDR_O,
   output logic CHIP_EN_N_O,
   output logic OUT_EN_N_O,
   output logic PROGRAM_STROBE_N_O,
   output logic PROG_VOLT_EN_O,
   output logic PROTECT_VOLTAGE_INPUT_O,
   output logic PROC_CLK_STOP_O,
   output logic [7:0] PROGRAMMER_DATA_LINES_O,
   output logic [7:0] PROGRAMMER_DATA_LINES_OE_O,
   input wire logic [7:0] DEVICE_DATA_LINES_I
);
   import opc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_SETUP,
      ST_PULSE,
      ST_VSETUP,
      ST_VSAMPLE,
      ST_FINAL,
      ST_READ,
      ST_PSETUP,
      ST_PPULSE,
      ST_DONE
   } opc_state_t;

   opc_state_t state_q;
   logic [2:0] cmd_q;
   opc_alg_t alg_q;
   logic [ADDR_W-1:0] addr_q;
   logic [15:0] wdata_q;
   logic hi_q;
   logic [4:0] tries_q;
   logic [15:0] rdata_q;
   logic busy_q;
   logic fail_q;
   logic limit_q;
   logic [ADDR_W-1:0] fail_addr_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic tmr_load;
   logic [TMR_W-1:0] tmr_cnt;
   logic tmr_done;
   logic [7:0] din_s;
   logic bus_req;
   logic go;
   logic [7:0] cur_byte;
   logic [ADDR_W-1:0] byte_addr;
   logic [TMR_W-1:0] pulse_cyc;
   logic [TMR_W-1:0] final_cyc;
   logic final_q;

   // Timer load and the state step after done each add one cycle to a pulse
   localparam int unsigned PULSE_TRIM = 2;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   opc_timer u_timer (
      .CLK_I(CLK_I),
      .RESET_I(RESET_I),
      .load_i(tmr_load),
      .count_i(tmr_cnt),
      .done_o(tmr_done)
   );

   // Device lines are asynchronous to our clock
   opc_sync #(.W(8)) u_sync (
      .CLK_I(CLK_I),
      .RESET_I(RESET_I),
      .async_i(DEVICE_DATA_LINES_I),
      .sync_o(din_s)
   );

   assign bus_req = CYC_I && STB_I && !ack_q;
   assign go = bus_req && WE_I && (ADR_I == REG_CTRL) && SEL_I[0] && DAT_I[CTRL_GO_BIT]
      && !busy_q;
   assign cur_byte = hi_q ? wdata_q[15:8] : wdata_q[7:0];
   // Word address shifted: low byte at even byte address
   assign byte_addr = {addr_q[ADDR_W-2:0], hi_q};
   assign pulse_cyc = (alg_q == OPC_ALG_STD) ? TMR_W'(PRIME_CYC) : TMR_W'(SHORT_CYC);
   assign final_cyc = TMR_W'(PRIME_CYC * FINAL_MULT * tries_q) - TMR_W'(PULSE_TRIM);

   // ------------------------------------------------------------
   // Wishbone slave: one wait state, ack for a single cycle
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= bus_req;
         dat_q <= '0;
         if (bus_req && !WE_I) begin
            unique case (ADR_I)
               REG_CTRL: dat_q <= {27'h0, 1'b0, alg_q == OPC_ALG_SHORT, cmd_q};
               REG_ADDR: dat_q <= {19'h0, addr_q};
               REG_DATA: dat_q <= {rdata_q, wdata_q};
               REG_STAT: dat_q <= {3'h0, fail_addr_q, 3'h0, tries_q, 5'h0, limit_q, fail_q,
                  busy_q};
               default: dat_q <= '0;
            endcase
         end
      end
   end

   assign ACK_O = ack_q;
   assign DAT_O = dat_q;

   // ------------------------------------------------------------
   // Software-written setup; ignored while busy
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cmd_q <= '0;
         alg_q <= OPC_ALG_STD;
         addr_q <= '0;
         wdata_q <= 16'hFFFF;
      end else if (bus_req && WE_I && !busy_q) begin
         if (ADR_I == REG_CTRL && SEL_I[0]) begin
            cmd_q <= DAT_I[2:0];
            alg_q <= opc_alg_t'(DAT_I[CTRL_ALG_BIT]);
         end
         if (ADR_I == REG_ADDR) begin
            addr_q <= DAT_I[ADDR_W-1:0];
         end
         if (ADR_I == REG_DATA) begin
            wdata_q <= DAT_I[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_q <= ST_IDLE;
         hi_q <= 1'b0;
         tries_q <= '0;
         rdata_q <= '0;
         busy_q <= 1'b0;
         fail_q <= 1'b0;
         limit_q <= 1'b0;
         fail_addr_q <= '0;
         final_q <= 1'b0;
         tmr_load <= 1'b0;
         tmr_cnt <= '0;
      end else begin
         tmr_load <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (go) begin
                  busy_q <= 1'b1;
                  fail_q <= 1'b0;
                  limit_q <= 1'b0;
                  final_q <= 1'b0;
                  hi_q <= 1'b0;
                  tries_q <= '0;
                  tmr_load <= 1'b1;
                  tmr_cnt <= TMR_W'(SETTLE_CYC);
                  unique case (DAT_I[2:0])
                     CMD_PROG: state_q <= ST_SETUP;
                     CMD_PROT: state_q <= ST_PSETUP;
                     CMD_READ, CMD_PVFY: state_q <= ST_READ;
                     default: begin
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_SETUP: begin
               // Strobe waits for address and data to settle
               if (tmr_done && !tmr_load) begin
                  tmr_load <= 1'b1;
                  if (final_q) begin
                     tmr_cnt <= final_cyc;
                     final_q <= 1'b0;
                     state_q <= ST_FINAL;
                  end else begin
                     tmr_cnt <= pulse_cyc - TMR_W'(PULSE_TRIM);
                     tries_q <= tries_q + 5'h01;
                     state_q <= ST_PULSE;
                  end
               end
            end
            ST_PULSE: begin
               if (tmr_done && !tmr_load) begin
                  tmr_load <= 1'b1;
                  tmr_cnt <= TMR_W'(SETTLE_CYC);
                  state_q <= ST_VSETUP;
               end
            end
            ST_VSETUP: begin
               // Extra cycles cover the two-stage synchroniser
               if (tmr_done && !tmr_load) begin
                  tmr_load <= 1'b1;
                  tmr_cnt <= TMR_W'(3);
                  state_q <= ST_VSAMPLE;
               end
            end
            ST_VSAMPLE: begin
               if (tmr_done && !tmr_load) begin
                  // Full byte must read back before it counts as done
                  if ((din_s & ~cur_byte) == 8'h00 && (din_s | ~cur_byte) == 8'hFF) begin
                     if (alg_q == OPC_ALG_STD) begin
                        // Final pulse gets its own settle gap after the verify read
                        final_q <= 1'b1;
                        tmr_load <= 1'b1;
                        tmr_cnt <= TMR_W'(SETTLE_CYC);
                        state_q <= ST_SETUP;
                     end else begin
                        state_q <= ST_FINAL;
                     end
                  end else if ((alg_q == OPC_ALG_STD && tries_q >= STD_MAX) ||
                               (alg_q == OPC_ALG_SHORT && tries_q >= SHORT_MAX)) begin
                     fail_q <= 1'b1;
                     limit_q <= 1'b1;
                     fail_addr_q <= byte_addr;
                     state_q <= ST_DONE;
                  end else begin
                     tmr_load <= 1'b1;
                     tmr_cnt <= TMR_W'(SETTLE_CYC);
                     state_q <= ST_SETUP;
                  end
               end
            end
            ST_FINAL: begin
               if (tmr_done && !tmr_load) begin
                  if (!hi_q) begin
                     tries_q <= '0;
                     hi_q <= 1'b1;
                     tmr_load <= 1'b1;
                     tmr_cnt <= TMR_W'(SETTLE_CYC);
                     state_q <= ST_SETUP;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_READ: begin
               // Read at normal conditions, used for the final verify pass; protect verify raises both voltages
               if (tmr_done && !tmr_load) begin
                  if (tries_q == 5'h04) begin
                     if (cmd_q == CMD_PVFY) begin
                        rdata_q <= {15'h0, din_s[PROT_BIT]};
                        state_q <= ST_DONE;
                     end else if (!hi_q) begin
                        rdata_q[7:0] <= din_s;
                        hi_q <= 1'b1;
                        tries_q <= '0;
                        tmr_load <= 1'b1;
                        tmr_cnt <= TMR_W'(SETTLE_CYC);
                     end else begin
                        rdata_q[15:8] <= din_s;
                        state_q <= ST_DONE;
                     end
                  end else begin
                     tries_q <= tries_q + 5'h01;
                  end
               end
            end
            ST_PSETUP: begin
               if (tmr_done && !tmr_load) begin
                  tmr_load <= 1'b1;
                  tmr_cnt <= TMR_W'(PROT_CYC);
                  state_q <= ST_PPULSE;
               end
            end
            ST_PPULSE: begin
               if (tmr_done && !tmr_load) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               busy_q <= 1'b0;
               // Program keeps its last attempt count for software
               if (cmd_q != CMD_PROG) begin
                  tries_q <= '0;
               end
               hi_q <= 1'b0;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin drive, all registered
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         MEM_ADDR_O <= '0;
         CHIP_EN_N_O <= 1'b1;
         OUT_EN_N_O <= 1'b1;
         PROGRAM_STROBE_N_O <= 1'b1;
         PROG_VOLT_EN_O <= 1'b0;
         PROTECT_VOLTAGE_INPUT_O <= 1'b0;
         PROC_CLK_STOP_O <= 1'b0;
         PROGRAMMER_DATA_LINES_O <= 8'hFF;
         PROGRAMMER_DATA_LINES_OE_O <= 8'h00;
      end else begin
         PROC_CLK_STOP_O <= busy_q || go;
         MEM_ADDR_O <= byte_addr;
         CHIP_EN_N_O <= 1'b1;
         OUT_EN_N_O <= 1'b1;
         PROGRAM_STROBE_N_O <= 1'b1;
         PROG_VOLT_EN_O <= 1'b0;
         PROTECT_VOLTAGE_INPUT_O <= 1'b0;
         PROGRAMMER_DATA_LINES_O <= 8'hFF;
         PROGRAMMER_DATA_LINES_OE_O <= 8'h00;
         unique case (state_q)
            ST_SETUP, ST_PULSE, ST_FINAL: begin
               CHIP_EN_N_O <= 1'b0;
               PROG_VOLT_EN_O <= 1'b1;
               PROGRAMMER_DATA_LINES_O <= cur_byte;
               PROGRAMMER_DATA_LINES_OE_O <= 8'hFF;
               // Short algorithm passes through final with the strobe high
               PROGRAM_STROBE_N_O <= !(state_q == ST_PULSE ||
                  (state_q == ST_FINAL && alg_q == OPC_ALG_STD));
            end
            ST_VSETUP, ST_VSAMPLE: begin
               CHIP_EN_N_O <= 1'b0;
               OUT_EN_N_O <= 1'b0;
               PROG_VOLT_EN_O <= 1'b1;
            end
            ST_READ: begin
               CHIP_EN_N_O <= 1'b0;
               OUT_EN_N_O <= 1'b0;
               if (cmd_q == CMD_PVFY) begin
                  MEM_ADDR_O <= PROT_ADDR;
                  PROG_VOLT_EN_O <= 1'b1;
                  // Protect voltage selects the cell onto the top line
                  PROTECT_VOLTAGE_INPUT_O <= 1'b1;
               end
            end
            ST_PSETUP, ST_PPULSE: begin
               // Enables and strobe held high throughout
               MEM_ADDR_O <= PROT_ADDR;
               PROG_VOLT_EN_O <= 1'b1;
               PROTECT_VOLTAGE_INPUT_O <= 1'b1;
               PROGRAMMER_DATA_LINES_OE_O <= 8'hFF;
               PROGRAMMER_DATA_LINES_O <= {state_q != ST_PPULSE, 7'h7F};
            end
            default: begin
            end
         endcase
      end
   end
endmodule // opc_ctrl
`default_nettype wire

// *** rtl/opc_pkg.sv ***
// Constants and types shared by the one-time-programmable memory programmer controller
// Notes on behaviour
// - Programmer writes only zeros; ones are left unprogrammed.
// - Byte is driven in parallel; strobe pulses only after address and data settle.
// - Locations may be programmed singly or as a block, in any order.
// - Standard algorithm: one millisecond prime pulse, then verify read.
// - Standard algorithm: repeat prime pulses on mismatch, fail at twenty-five.
// - Standard algorithm: after pass at X pulses, final pulse of 3X ms.
// - After programming, a separate verification pass at normal read conditions.
// - Short-pulse algorithm: 100 microsecond pulse, then verify read.
// - Short-pulse algorithm: fail only after ten failed pulse-and-verify attempts.
// - Protect: enables, strobe, address bit four high, raise voltages, pulse top line low.
// - Each 16-bit word is loaded low byte first, then high byte.
// - Processor clock stays stopped during any programming or verify mode.
`default_nettype none

package opc_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned PRIME_US = 1000;
   localparam int unsigned SHORT_US = 100;
   localparam int unsigned PRIME_CYC = PRIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SHORT_CYC = SHORT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SETTLE_NS = 200;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned PROT_US = 100;
   localparam int unsigned PROT_CYC = PROT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TMR_W = 24;

   // ------------------------------------------------------------
   // Retry limits and widths
   // ------------------------------------------------------------
   localparam logic [4:0] STD_MAX = 5'h19;
   localparam logic [4:0] SHORT_MAX = 5'h0A;
   localparam logic [4:0] FINAL_MULT = 5'h03;
   localparam int unsigned ADDR_W = 13;
   localparam logic [ADDR_W-1:0] PROT_ADDR = 13'h0010;
   localparam int unsigned PROT_BIT = 7;

   // ------------------------------------------------------------
   // Register map (Wishbone word offsets as byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hC;
   localparam logic [2:0] CMD_PROG = 3'h1;
   localparam logic [2:0] CMD_READ = 3'h2;
   localparam logic [2:0] CMD_PROT = 3'h3;
   localparam logic [2:0] CMD_PVFY = 3'h4;
   localparam int unsigned CTRL_ALG_BIT = 3;
   localparam int unsigned CTRL_GO_BIT = 4;

   typedef enum logic [0:0] {
      OPC_ALG_STD,
      OPC_ALG_SHORT
   } opc_alg_t;

endpackage : opc_pkg

`default_nettype wire

// *** rtl/opc_sync.sv ***
// Two flip-flop synchroniser for the device data lines
`default_nettype none

module opc_sync #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // opc_sync
`default_nettype wire

// *** rtl/opc_timer.sv ***
// Down-counting pulse timer for strobe widths
`default_nettype none

module opc_timer (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Control
   input wire logic load_i,
   input wire logic [opc_pkg::TMR_W-1:0] count_i,
   // Status
   output logic done_o
);
   import opc_pkg::*;

   logic [TMR_W-1:0] cnt_q;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= count_i;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign done_o = (cnt_q == '0) && !load_i;
endmodule // opc_timer
`default_nettype wire
